// ==== rtl/rcm_counter_control.v ====
`timescale 1ns/1ps
`include "rcm_defines.vh"
// Summary of operation
// - Each falling first-decade edge outside the blanking window becomes one shaped count pulse of about 40 ns.
// - Difference mode preloads stored centre, counts down to zero, then counts up.
// - Count pulse is blanked when direction flag falls from reverse to forward.
// - Shaped pulse goes to forward or reverse input according to direction flag.
// - Gate end emits transfer of counter into main latches unless inhibited.
// - After transfer, in past centre or difference mode with centre done, a second pulse preloads the counter from centre latches.
// - The complementary phase of that second pulse resets the count chain.
// - Chain reset is inverted to active low and clears the first decade.
// - Difference mode blocks main-latch transfer at end of centre measurement.
// - Difference inhibit holds while centre not done; next gate end then clears it.
// - Past centre or bright line: start presets inhibit, first gate end clears it.
// - Modes are exclusive; bright line cancels past centre and difference.
// - Upper stages are reversible decades plus one toggle stage as top digits.
// - Every decade owns a main latch and a centre frequency latch.
// - All-zero chain while reversing in difference mode is detected and signalled.
// - 1 kHz reference divided by ten, decoded into nine one-hot digit selects.
// - Each select puts one main latch digit onto the shared digit bus.
// - Forward carries feed next forward input, reverse borrows feed next reverse.
// - On reverse all-zero, direction goes forward and first decade is reset.
// - End of centre measurement captures the count once into centre latches.
module rcm_counter_control #(
  parameter SHAPE_CYC = `RCM_SHAPE_CYC
) (
  input  wire        SYS_CLK,          // System clock, 100 MHz
  input  wire        SRST,             // Synchronous reset, active high
  input  wire        FIRST_DEC_OUT,    // First decade output pin
  input  wire [3:0]  FIRST_BCD,        // First decade BCD readout pin
  input  wire        GATE_IN,          // Gating waveform pin, end on fall
  input  wire        REF_1KHZ,         // Display reference pin
  input  wire [3:0]  AVS_ADDRESS,      // Avalon byte address
  input  wire        AVS_READ,         // Avalon read
  input  wire        AVS_WRITE,        // Avalon write
  input  wire [31:0] AVS_WRITEDATA,    // Avalon write data
  output reg  [31:0] AVS_READDATA,     // Avalon read data
  output reg         AVS_WAITREQUEST,  // Avalon wait request
  output reg         CHAIN_FWD_PULSE,  // Shaped forward count pulse
  output reg         CHAIN_REV_PULSE,  // Shaped reverse count pulse
  output reg         FIRST_RST_N,      // First decade clear, active low
  output reg         FIRST_PRESET_STB, // First decade preload strobe
  output reg  [3:0]  FIRST_PRESET_BCD, // First decade preload value
  output reg         DIR_REVERSE,      // Direction flag, high for reverse
  output reg         ZERO_DET,         // All-zero detect strobe
  output reg  [8:0]  DIGIT_SEL,        // One-hot digit select
  output reg  [3:0]  DIGIT_BCD         // Shared digit bus
);

  // ****************************************
  // Functions
  // ****************************************
  // One-hot select from divider count; last count selects nothing
  function [8:0] sel_dec;
    input [3:0] cnt;
    begin
      if (cnt < `RCM_DIV_LAST) begin
        sel_dec = 9'h001 << cnt;
      end else begin
        sel_dec = 9'h000;
      end
    end
  endfunction

  // BCD step up or down
  function [3:0] bcd_step;
    input [3:0] d;
    input       down;
    begin
      if (down) begin
        bcd_step = (d == `RCM_BCD_ZERO) ? `RCM_BCD_MAX : d - 4'h1;
      end else begin
        bcd_step = (d == `RCM_BCD_MAX) ? `RCM_BCD_ZERO : d + 4'h1;
      end
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  reg  [6:0]  sy1_ff;
  reg  [6:0]  sy2_ff;
  reg  [6:0]  sy3_ff;
  reg  [6:0]  filt_ff;
  reg  [6:0]  prev_ff;
  reg  [31:0] cnt_ff;
  reg  [31:0] nxt_cnt;
  reg  [35:0] main_ff;
  reg  [35:0] centre_ff;
  reg  [3:0]  blank_ff;
  reg  [3:0]  shp_ff;
  reg         dir_ff;
  reg         dir_d_ff;
  reg         cdone_ff;
  reg         inhib_ff;
  reg         zero_seen_ff;
  reg         diff_ff;
  reg         pc_ff;
  reg         bright_ff;
  reg         stage1_ff;
  reg         stage2_ff;
  reg  [3:0]  div_ff;
  reg         carry;
  reg  [3:0]  dig;
  integer     i;

  wire        first_fall;
  wire        gate_end;
  wire        ref_rise;
  wire [3:0]  first_bcd_s;
  wire        accept;
  wire        centre_pend;
  wire        preload_en;
  wire        zero_hit;
  wire        wr_acc;
  wire        start;

  assign first_bcd_s = filt_ff[6:3];
  assign first_fall  = prev_ff[0] & ~filt_ff[0];
  assign gate_end    = prev_ff[1] & ~filt_ff[1];
  assign ref_rise    = ~prev_ff[2] & filt_ff[2];
  assign accept      = first_fall & (blank_ff == 4'h0);
  assign centre_pend = (diff_ff | pc_ff) & ~cdone_ff;
  assign preload_en  = (diff_ff | pc_ff) & cdone_ff;
  assign zero_hit    = diff_ff & dir_ff & (cnt_ff == 32'h0000_0000)
                       & (first_bcd_s == `RCM_BCD_ZERO) & ~stage2_ff;
  assign wr_acc      = AVS_WRITE & ~AVS_WAITREQUEST;
  assign start       = wr_acc & (AVS_ADDRESS == `RCM_OFS_CTRL)
                       & AVS_WRITEDATA[`RCM_CTRL_START];

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Three stages; filtered value moves once stages two and three agree
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      sy1_ff  <= 7'h00;
      sy2_ff  <= 7'h00;
      sy3_ff  <= 7'h00;
      filt_ff <= 7'h00;
      prev_ff <= 7'h00;
    end else begin
      sy1_ff  <= {FIRST_BCD, REF_1KHZ, GATE_IN, FIRST_DEC_OUT};
      sy2_ff  <= sy1_ff;
      sy3_ff  <= sy2_ff;
      filt_ff <= (filt_ff & (sy2_ff ^ sy3_ff)) | (sy3_ff & ~(sy2_ff ^ sy3_ff));
      prev_ff <= filt_ff;
    end
  end

  // ****************************************
  // Count pulse shaping and steering
  // ****************************************
  // Shaped pulse, blanked after a reverse-to-forward change
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      blank_ff        <= 4'h0;
      shp_ff          <= 4'h0;
      CHAIN_FWD_PULSE <= 1'b0;
      CHAIN_REV_PULSE <= 1'b0;
      dir_d_ff        <= 1'b0;
    end else begin
      dir_d_ff <= dir_ff;
      if (dir_d_ff & ~dir_ff) begin
        blank_ff <= `RCM_BLANK_CYC;
      end else if (blank_ff != 4'h0) begin
        blank_ff <= blank_ff - 4'h1;
      end
      if (accept) begin
        shp_ff          <= SHAPE_CYC[3:0] - 4'h1;
        CHAIN_FWD_PULSE <= ~dir_ff;
        CHAIN_REV_PULSE <= dir_ff;
      end else if (shp_ff != 4'h0) begin
        shp_ff <= shp_ff - 4'h1;
      end else begin
        CHAIN_FWD_PULSE <= 1'b0;
        CHAIN_REV_PULSE <= 1'b0;
      end
    end
  end

  // ****************************************
  // Reversible chain with toggle stage
  // ****************************************
  // Carry or borrow ripples from decade to decade
  always @* begin
    nxt_cnt = cnt_ff;
    carry   = 1'b1;
    dig     = 4'h0;
    for (i = 0; i < `RCM_UPPER_DEC; i = i + 1) begin
      dig = cnt_ff[4*i +: 4];
      if (carry) begin
        nxt_cnt[4*i +: 4] = bcd_step(dig, dir_ff);
        carry = dir_ff ? (dig == `RCM_BCD_ZERO) : (dig == `RCM_BCD_MAX);
      end
    end
    if (carry) begin
      nxt_cnt[28] = ~cnt_ff[28];
    end
    nxt_cnt[31:29] = 3'h0;
  end

  // ****************************************
  // Gate-end sequence and chain update
  // ****************************************
  // Gate end, then transfer, then preload or reset, one cycle apart
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      stage1_ff        <= 1'b0;
      stage2_ff        <= 1'b0;
      cnt_ff           <= 32'h0000_0000;
      main_ff          <= 36'h0_0000_0000;
      centre_ff        <= 36'h0_0000_0000;
      cdone_ff         <= 1'b0;
      dir_ff           <= 1'b0;
      FIRST_RST_N      <= 1'b1;
      FIRST_PRESET_STB <= 1'b0;
      FIRST_PRESET_BCD <= 4'h0;
      ZERO_DET         <= 1'b0;
      zero_seen_ff     <= 1'b0;
    end else begin
      stage1_ff        <= gate_end;
      stage2_ff        <= stage1_ff;
      FIRST_RST_N      <= 1'b1;
      FIRST_PRESET_STB <= 1'b0;
      ZERO_DET         <= 1'b0;
      if (stage1_ff & ~inhib_ff) begin
        main_ff <= {cnt_ff[31:0], first_bcd_s};
      end
      if (stage1_ff & centre_pend) begin
        centre_ff <= {cnt_ff[31:0], first_bcd_s};
        cdone_ff  <= 1'b1;
      end else if (start) begin
        cdone_ff <= 1'b0;
      end
      if (stage2_ff & preload_en) begin
        cnt_ff           <= centre_ff[35:4];
        FIRST_PRESET_STB <= 1'b1;
        FIRST_PRESET_BCD <= centre_ff[3:0];
        dir_ff           <= diff_ff;
      end else if (stage2_ff) begin
        cnt_ff      <= 32'h0000_0000;
        FIRST_RST_N <= 1'b0;
        dir_ff      <= 1'b0;
      end else if (zero_hit) begin
        dir_ff      <= 1'b0;
        FIRST_RST_N <= 1'b0;
        ZERO_DET    <= 1'b1;
      end else if (accept) begin
        cnt_ff <= nxt_cnt;
      end
      if (zero_hit & ~stage2_ff) begin
        zero_seen_ff <= 1'b1;
      end else if (start) begin
        zero_seen_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Latch-transfer inhibit
  // ****************************************
  // Difference holds it until centre done; other modes clear at gate end
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      inhib_ff <= 1'b0;
    end else if (diff_ff) begin
      if (~cdone_ff | start) begin
        inhib_ff <= 1'b1;
      end else if (gate_end) begin
        inhib_ff <= 1'b0;
      end
    end else if (start) begin
      inhib_ff <= 1'b1;
    end else if (gate_end) begin
      inhib_ff <= 1'b0;
    end
  end

  // ****************************************
  // Mode register
  // ****************************************
  // Bright line wins; difference wins over past centre
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      diff_ff   <= 1'b0;
      pc_ff     <= 1'b0;
      bright_ff <= 1'b0;
    end else if (wr_acc & (AVS_ADDRESS == `RCM_OFS_CTRL)) begin
      bright_ff <= AVS_WRITEDATA[`RCM_CTRL_BRIGHT];
      diff_ff   <= AVS_WRITEDATA[`RCM_CTRL_DIFF] & ~AVS_WRITEDATA[`RCM_CTRL_BRIGHT];
      pc_ff     <= AVS_WRITEDATA[`RCM_CTRL_PC] & ~AVS_WRITEDATA[`RCM_CTRL_DIFF]
                   & ~AVS_WRITEDATA[`RCM_CTRL_BRIGHT];
    end
  end

  // ****************************************
  // Display multiplexer
  // ****************************************
  // Divide-by-ten on reference edges, one digit per select
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      div_ff    <= 4'h0;
      DIGIT_SEL <= 9'h000;
      DIGIT_BCD <= 4'h0;
    end else begin
      if (ref_rise) begin
        div_ff <= (div_ff == `RCM_DIV_LAST) ? 4'h0 : div_ff + 4'h1;
      end
      DIGIT_SEL <= sel_dec(div_ff);
      if (div_ff < `RCM_DIV_LAST) begin
        DIGIT_BCD <= main_ff[4*div_ff +: 4];
      end else begin
        DIGIT_BCD <= 4'h0;
      end
    end
  end

  // ****************************************
  // Avalon slave
  // ****************************************
  // One wait cycle per access; read data ready when wait drops
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
      DIR_REVERSE     <= 1'b0;
    end else begin
      DIR_REVERSE <= dir_ff;
      if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        if (AVS_ADDRESS == `RCM_OFS_CTRL) begin
          AVS_READDATA <= {29'h0000_0000, bright_ff, pc_ff, diff_ff};
        end else if (AVS_ADDRESS == `RCM_OFS_STATUS) begin
          AVS_READDATA <= {28'h000_0000, zero_seen_ff, inhib_ff, cdone_ff, dir_ff};
        end else if (AVS_ADDRESS == `RCM_OFS_MAIN_LO) begin
          AVS_READDATA <= main_ff[31:0];
        end else if (AVS_ADDRESS == `RCM_OFS_MAIN_HI) begin
          AVS_READDATA <= {28'h000_0000, main_ff[35:32]};
        end else begin
          AVS_READDATA <= 32'h0000_0000;
        end
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

endmodule

// ==== rtl/rcm_defines.vh ====
`ifndef RCM_DEFINES_VH
`define RCM_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define RCM_CLK_MHZ        100
`define RCM_SHAPE_NS       40
`define RCM_SHAPE_CYC      ((`RCM_SHAPE_NS * `RCM_CLK_MHZ + 999) / 1000)
`define RCM_BLANK_CYC      4'h8

// ****************************************
// Register byte offsets
// ****************************************
`define RCM_OFS_CTRL       4'h0
`define RCM_OFS_STATUS     4'h4
`define RCM_OFS_MAIN_LO    4'h8
`define RCM_OFS_MAIN_HI    4'hC

// ****************************************
// Field positions
// ****************************************
`define RCM_CTRL_DIFF      0
`define RCM_CTRL_PC        1
`define RCM_CTRL_BRIGHT    2
`define RCM_CTRL_START     3
`define RCM_ST_DIR         0
`define RCM_ST_CDONE       1
`define RCM_ST_INHIB       2
`define RCM_ST_ZERO        3

// ****************************************
// Values
// ****************************************
`define RCM_BCD_MAX        4'h9
`define RCM_BCD_ZERO       4'h0
`define RCM_DIV_LAST       4'h9
`define RCM_NDIG           9
`define RCM_UPPER_DEC      7

`endif

// ==== verif/rcm_counter_control_assertions.sv ====
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module rcm_checker #(
  parameter SHAPE_CYC = 4
) (
  input wire       SYS_CLK,          // Clock
  input wire       SRST,             // Reset
  input wire       AVS_READ,         // Bus read
  input wire       AVS_WRITE,        // Bus write
  input wire       AVS_WAITREQUEST,  // Bus wait
  input wire       CHAIN_FWD_PULSE,  // Forward pulse
  input wire       CHAIN_REV_PULSE,  // Reverse pulse
  input wire       FIRST_RST_N,      // First decade clear
  input wire       FIRST_PRESET_STB, // Preload strobe
  input wire       DIR_REVERSE,      // Direction flag
  input wire       ZERO_DET,         // Zero strobe
  input wire [8:0] DIGIT_SEL         // Digit selects
);
  default clocking dcb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  // Count pulse shape and steering
  property p_shape; $rose(CHAIN_FWD_PULSE) |-> CHAIN_FWD_PULSE[*4]; endproperty
  a_shape: assert property (p_shape) else $error("forward pulse too short");
  property p_steer; !(CHAIN_FWD_PULSE && CHAIN_REV_PULSE); endproperty
  a_steer: assert property (p_steer) else $error("both count inputs driven");
  property p_blank; $fell(DIR_REVERSE) |-> (!$rose(CHAIN_FWD_PULSE))[*6]; endproperty
  a_blank: assert property (p_blank) else $error("carry not blanked");

  // End of gate strobes
  property p_clr; !FIRST_RST_N |=> FIRST_RST_N; endproperty
  a_clr: assert property (p_clr) else $error("clear longer than one cycle");
  property p_pre; FIRST_PRESET_STB |-> FIRST_RST_N ##1 !FIRST_PRESET_STB; endproperty
  a_pre: assert property (p_pre) else $error("preload overlaps clear");

  // Zero detect and direction
  property p_zero; ZERO_DET |-> $past(DIR_REVERSE); endproperty
  a_zero: assert property (p_zero) else $error("zero while forward");
  property p_turn; ZERO_DET |-> !FIRST_RST_N ##1 !DIR_REVERSE; endproperty
  a_turn: assert property (p_turn) else $error("no turn at zero");

  // Display and bus
  property p_sel; $onehot0(DIGIT_SEL); endproperty
  a_sel: assert property (p_sel) else $error("digit select not one-hot");
  property p_ans; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
endmodule

bind rcm_counter_control rcm_checker #(.SHAPE_CYC(SHAPE_CYC)) u_chk (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CHAIN_FWD_PULSE(CHAIN_FWD_PULSE),
  .CHAIN_REV_PULSE(CHAIN_REV_PULSE), .FIRST_RST_N(FIRST_RST_N),
  .FIRST_PRESET_STB(FIRST_PRESET_STB), .DIR_REVERSE(DIR_REVERSE),
  .ZERO_DET(ZERO_DET), .DIGIT_SEL(DIGIT_SEL));

// ==== verif/rcm_first_decade_model.sv ====
`timescale 1ns/1ps
// ****************************************
// First decade and display decoder
// ****************************************
module rcm_first_decade_model (
  input  wire       SYS_CLK,          // Clock
  input  wire       FIRST_RST_N,      // Clear, active low
  input  wire       FIRST_PRESET_STB, // Preload strobe
  input  wire [3:0] FIRST_PRESET_BCD, // Preload value
  input  wire       DIR_REVERSE,      // Direction flag
  input  wire [8:0] DIGIT_SEL,        // Digit selects
  input  wire [3:0] DIGIT_BCD,        // Digit bus
  output wire       FIRST_DEC_OUT,    // Carry or borrow output
  output wire [3:0] FIRST_BCD         // Decade readout
);
  reg     [3:0] bcd_ff;
  reg           step_ff;
  reg     [3:0] shown_ff [0:8];
  integer       i;

  // Output falls on 9 to 0 forward, 0 to 9 reverse, and on a reverse to forward flip
  assign FIRST_DEC_OUT = DIR_REVERSE ? (bcd_ff != 4'h9) : bcd_ff[3];
  assign FIRST_BCD     = bcd_ff;

  // Decade count, clear, preload and display capture
  initial bcd_ff = 4'h0;
  initial step_ff = 1'h0;
  always @(posedge SYS_CLK) begin
    if (!FIRST_RST_N) begin
      bcd_ff <= 4'h0;
    end else if (FIRST_PRESET_STB) begin
      bcd_ff <= FIRST_PRESET_BCD;
    end else if (step_ff && DIR_REVERSE) begin
      bcd_ff <= (bcd_ff == 4'h0) ? 4'h9 : bcd_ff - 4'h1;
    end else if (step_ff) begin
      bcd_ff <= (bcd_ff == 4'h9) ? 4'h0 : bcd_ff + 4'h1;
    end
    for (i = 0; i < 9; i = i + 1) begin
      if (DIGIT_SEL[i]) shown_ff[i] <= DIGIT_BCD;
    end
  end

  // Input counts, spaced well apart
  task step(input integer n);
    begin
      repeat (n) begin
        @(posedge SYS_CLK);
        step_ff <= 1'h1;
        @(posedge SYS_CLK);
        step_ff <= 1'h0;
        repeat (10) @(posedge SYS_CLK);
      end
    end
  endtask
endmodule

// ==== verif/reversible_counter_control_mux_tb.sv ====
`timescale 1ns/1ps
module reversible_counter_control_mux_tb;
  // ****************************************
  // Signals
  // ****************************************
  reg         clk, srst, gate_in, ref_clk, avs_read, avs_write, fwd_d, rev_d;
  reg  [3:0]  avs_address;
  reg  [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire        waitreq, fwd, rev, rst_n, pre_stb, dir_rev, zero, dec_out;
  wire [3:0]  pre_bcd, first_bcd, dig_bcd;
  wire [8:0]  dig_sel;
  integer     fails, checked, fwd_n, rev_n, zero_n, ref_n;

  rcm_counter_control u_dut (
    .SYS_CLK(clk), .SRST(srst), .FIRST_DEC_OUT(dec_out), .FIRST_BCD(first_bcd),
    .GATE_IN(gate_in), .REF_1KHZ(ref_clk), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(waitreq), .CHAIN_FWD_PULSE(fwd), .CHAIN_REV_PULSE(rev),
    .FIRST_RST_N(rst_n), .FIRST_PRESET_STB(pre_stb), .FIRST_PRESET_BCD(pre_bcd),
    .DIR_REVERSE(dir_rev), .ZERO_DET(zero), .DIGIT_SEL(dig_sel), .DIGIT_BCD(dig_bcd));

  rcm_first_decade_model u_far (
    .SYS_CLK(clk), .FIRST_RST_N(rst_n), .FIRST_PRESET_STB(pre_stb),
    .FIRST_PRESET_BCD(pre_bcd), .DIR_REVERSE(dir_rev), .DIGIT_SEL(dig_sel),
    .DIGIT_BCD(dig_bcd), .FIRST_DEC_OUT(dec_out), .FIRST_BCD(first_bcd));

  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Pulse counting and a sped up display reference
  always @(posedge clk) begin
    fwd_d <= fwd;
    rev_d <= rev;
    if (fwd && !fwd_d) fwd_n = fwd_n + 1;
    if (rev && !rev_d) rev_n = rev_n + 1;
    if (zero) zero_n = zero_n + 1;
    ref_n = (ref_n == 19) ? 0 : ref_n + 1;
    if (ref_n == 0) ref_clk <= ~ref_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task bus(input wr, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (waitreq !== 1'h0 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 50) fails = fails + 1;
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
    end
  endtask

  task rd_chk(input [3:0] a, input [31:0] exp);
    begin
      bus(1'h0, a, 32'h0);
      chk(rd, exp);
    end
  endtask

  task gate_end;
    begin
      gate_in <= 1'h1;
      repeat (10) @(posedge clk);
      gate_in <= 1'h0;
      repeat (20) @(posedge clk);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    begin
      chk({31'h0, waitreq}, 32'h1);
      chk({31'h0, rst_n}, 32'h1);
      chk({23'h0, dig_sel}, 32'h0);
      rd_chk(4'h4, 32'h0);
      rd_chk(4'h8, 32'h0);
    end
  endtask

  task t_modes;
    begin
      bus(1'h1, 4'h4, 32'hF);
      rd_chk(4'h4, 32'h0);
      bus(1'h1, 4'h0, 32'h7);
      rd_chk(4'h0, 32'h4);
      bus(1'h1, 4'h0, 32'h3);
      rd_chk(4'h0, 32'h1);
      bus(1'h1, 4'h2, 32'hF);
      rd_chk(4'h2, 32'h0);
    end
  endtask

  task t_bright;
    begin
      bus(1'h1, 4'h0, 32'hC);
      fwd_n = 0;
      rev_n = 0;
      u_far.step(125);
      gate_end;
      rd_chk(4'h8, 32'h125);
      rd_chk(4'hC, 32'h0);
      chk(fwd_n, 12);
      chk(rev_n, 0);
      repeat (450) @(posedge clk);
      chk(u_far.shown_ff[0], 5);
      chk(u_far.shown_ff[2], 1);
      u_far.step(3);
      gate_end;
      rd_chk(4'h8, 32'h3);
    end
  endtask

  task t_diff;
    begin
      bus(1'h1, 4'h0, 32'h9);
      u_far.step(123);
      gate_end;
      rd_chk(4'h8, 32'h3);
      rd_chk(4'h4, 32'h7);
      chk(first_bcd, 3);
      fwd_n = 0;
      rev_n = 0;
      zero_n = 0;
      u_far.step(130);
      chk(fwd_n, 0);
      chk(rev_n, 12);
      chk(zero_n, 1);
      rd_chk(4'h4, 32'hE);
      gate_end;
      rd_chk(4'h8, 32'h7);
    end
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  // Hang guard
  initial begin
    #300000;
    fails = fails + 1;
    end_sim;
  end

  // Main sequence
  initial begin
    srst = 1'h1;
    gate_in = 1'h0;
    ref_clk = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    fails = 0;
    checked = 0;
    fwd_n = 0;
    rev_n = 0;
    zero_n = 0;
    ref_n = 0;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    t_reset;
    t_modes;
    t_bright;
    t_diff;
    end_sim;
  end
endmodule
